// File: hdl/serial_unit.sv
// asynchronous serial unit: receiver and transmitter with error checks and multiprocessor format
`timescale 1ns/100ps
`default_nettype none
module serial_unit (
  input  wire logic        core_clk_i,            // system clock
  input  wire logic        sys_rst_i,             // synchronous reset, active high
  input  wire logic [15:0] baud_div_i,            // sample tick every baud_div_i+1 clocks
  input  wire logic        seven_bit_i,           // 7-bit characters when high
  input  wire logic        parity_en_i,           // parity bit present
  input  wire logic        parity_odd_i,          // odd parity when high
  input  wire logic        multiproc_i,           // multiprocessor format
  input  wire logic        two_stop_i,            // two stop bits when high
  input  wire logic        rx_enable_i,           // receiver enable
  input  wire logic        tx_enable_i,           // transmitter enable
  input  wire logic        rx_irq_enable_i,       // receive and error request enable
  input  wire logic        tx_empty_irq_enable_i, // transmit-empty request enable
  input  wire logic        tx_end_irq_enable_i,   // transmit-end request enable
  input  wire logic        rx_line_i,             // receive line
  input  wire logic        rx_full_clr_i,         // pulse: clear receive-full
  input  wire logic        err_clr_i,             // pulse: clear all error flags
  input  wire logic        id_wait_set_i,         // pulse: arm id wait
  input  wire logic        tx_write_i,            // pulse: write transmit data
  input  wire logic [7:0]  tx_data_i,             // transmit data to store
  input  wire logic        id_bit_to_send_i,      // id bit for the next frame
  input  wire logic        tx_empty_clr_i,        // pulse: clear transmit-empty
  output logic             tx_line_o,             // transmit line
  output logic [7:0]       rx_data_o,             // receive data register
  output logic             rx_full_flag_o,        // receive data full
  output logic             overrun_flag_o,        // overrun error
  output logic             framing_err_flag_o,    // framing error
  output logic             parity_err_flag_o,     // parity error
  output logic             id_flag_bit_o,         // id bit of the last loaded frame
  output logic             id_wait_enable_o,      // id wait armed
  output logic             tx_empty_flag_o,       // transmit data register empty
  output logic             tx_end_flag_o,         // transmission ended
  output logic             rx_full_irq_o,         // receive-data-full request
  output logic             rx_error_irq_o,        // receive-error request
  output logic             tx_empty_irq_o,        // transmit-empty request
  output logic             tx_end_irq_o           // transmit-end request
);
  import serial_unit_pkg::*;

  // ==========================================================
  // sample tick divider
  logic [15:0] div_cnt_ff;   // divider count
  logic        tick_ff;      // one-cycle sample tick
  wire         div_wrap = (div_cnt_ff == baud_div_i);

  // tick pulses once per wrap of the divider
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      div_cnt_ff <= DIV_RESET;
      tick_ff    <= 1'b0;
    end else begin
      div_cnt_ff <= div_wrap ? DIV_RESET : div_cnt_ff + 16'h0001;
      tick_ff    <= div_wrap;
    end
  end

  // ==========================================================
  // receiver
  rx_state_t   rx_state_ff;       // receiver state
  logic [3:0]  rx_sub_ff;         // sample tick within a bit
  logic [2:0]  rx_idx_ff;         // data bit index
  logic [7:0]  rx_shift_reg_ff;   // receive shift register
  logic        rx_extra_ff;       // parity or id bit received
  logic [7:0]  rx_data_reg_ff;    // receive data register
  logic        rx_full_flag_ff;
  logic        overrun_flag_ff;
  logic        framing_err_flag_ff;
  logic        parity_err_flag_ff;
  logic        id_flag_bit_ff;
  logic        id_wait_enable_ff;

  wire rx_err_any    = overrun_flag_ff | framing_err_flag_ff | parity_err_flag_ff;
  wire rx_bit_end    = tick_ff & (rx_sub_ff == SUB_LAST);
  wire rx_mid_start  = tick_ff & (rx_sub_ff == SUB_MID);
  wire rx_last_data  = (rx_idx_ff == (seven_bit_i ? IDX_LAST_7 : IDX_LAST_8));
  wire has_extra     = parity_en_i | multiproc_i;
  wire frame_done    = (rx_state_ff == RX_STOP) & rx_bit_end;
  // a 7-bit character ends up in bits 7..1 after shifting in from the top
  wire [7:0] rx_char = seven_bit_i ? {1'b0, rx_shift_reg_ff[7:1]} : rx_shift_reg_ff;
  // parity is only judged when a parity bit exists outside mp format
  wire parity_bad    = parity_en_i & ~multiproc_i & (^rx_char ^ rx_extra_ff ^ parity_odd_i);
  wire stop_bad      = ~rx_line_i;
  wire frame_skip    = multiproc_i & id_wait_enable_ff & ~rx_extra_ff;
  wire id_frame      = frame_done & multiproc_i & rx_extra_ff;
  wire do_overrun    = frame_done & ~frame_skip & rx_full_flag_ff;
  wire do_load       = frame_done & ~frame_skip & ~rx_full_flag_ff;
  wire set_full      = do_load & ~stop_bad & ~parity_bad;

  // receive sequencer; only the first stop bit is sampled, a second one is idle time
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i || !rx_enable_i) begin
      rx_state_ff <= RX_IDLE;
      rx_sub_ff   <= 4'h0;
      rx_idx_ff   <= 3'h0;
    end else begin
      rx_sub_ff <= tick_ff ? rx_sub_ff + 4'h1 : rx_sub_ff;
      case (rx_state_ff)
        // hunt for the falling edge while no error is pending
        RX_IDLE: begin
          rx_sub_ff <= 4'h0;
          if (tick_ff && !rx_line_i && !rx_err_any) begin
            rx_state_ff <= RX_START;
          end
        end
        // confirm the start bit at its centre and realign there
        RX_START: begin
          if (rx_mid_start) begin
            rx_sub_ff   <= 4'h0;
            rx_idx_ff   <= 3'h0;
            rx_state_ff <= rx_line_i ? RX_IDLE : RX_DATA;
          end
        end
        // data bits at bit centres
        RX_DATA: begin
          if (rx_bit_end) begin
            rx_idx_ff <= rx_idx_ff + 3'h1;
            if (rx_last_data) begin
              rx_state_ff <= has_extra ? RX_EXTRA : RX_STOP;
            end
          end
        end
        // parity or id bit
        RX_EXTRA: begin
          if (rx_bit_end) begin
            rx_state_ff <= RX_STOP;
          end
        end
        // first stop bit, then back to hunting
        RX_STOP: begin
          if (rx_bit_end) begin
            rx_state_ff <= RX_IDLE;
          end
        end
        default: rx_state_ff <= RX_IDLE;
      endcase
    end
  end

  // shift register fills from the top so the first bit of an 8-bit character lands in bit 0
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      rx_shift_reg_ff <= DATA_RST;
      rx_extra_ff     <= 1'b0;
    end else if (rx_bit_end && rx_state_ff == RX_DATA) begin
      rx_shift_reg_ff <= {rx_line_i, rx_shift_reg_ff[7:1]};
    end else if (rx_bit_end && rx_state_ff == RX_EXTRA) begin
      rx_extra_ff <= rx_line_i;
    end else if (rx_state_ff == RX_START) begin
      rx_extra_ff <= 1'b0;  // no extra bit reads as zero
    end
  end

  // data register: loaded on clean frames and on framing or parity errors
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      rx_data_reg_ff <= DATA_RST;
      id_flag_bit_ff <= 1'b0;
    end else if (do_load) begin
      rx_data_reg_ff <= rx_char;
      id_flag_bit_ff <= multiproc_i & rx_extra_ff;
    end
  end

  // status flags: a hardware set beats a same-cycle clear
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      rx_full_flag_ff     <= 1'b0;
      overrun_flag_ff     <= 1'b0;
      framing_err_flag_ff <= 1'b0;
      parity_err_flag_ff  <= 1'b0;
      id_wait_enable_ff   <= 1'b0;
    end else begin
      rx_full_flag_ff     <= set_full | (rx_full_flag_ff & ~rx_full_clr_i);
      overrun_flag_ff     <= do_overrun | (overrun_flag_ff & ~err_clr_i);
      framing_err_flag_ff <= (do_load & stop_bad) | (framing_err_flag_ff & ~err_clr_i);
      parity_err_flag_ff  <= (do_load & parity_bad) | (parity_err_flag_ff & ~err_clr_i);
      // an id frame drops the wait and is then received like any frame
      id_wait_enable_ff   <= id_wait_set_i | (id_wait_enable_ff & ~id_frame);
    end
  end

  // ==========================================================
  // transmitter
  tx_state_t   tx_state_ff;       // transmitter state
  logic [3:0]  tx_sub_ff;         // sample tick within a bit
  logic [2:0]  tx_idx_ff;         // data bit index
  logic [7:0]  tx_data_reg_ff;    // transmit data register
  logic [7:0]  tx_shift_reg_ff;   // transmit shift register
  logic        tx_extra_ff;       // parity or id bit to send
  logic        tx_line_ff;        // line driver
  logic        tx_stop2_ff;       // second stop bit in progress
  logic        tx_chain_ff;       // next frame already loaded
  logic        tx_empty_flag_ff;
  logic        tx_end_flag_ff;

  wire tx_bit_end     = tick_ff & (tx_sub_ff == SUB_LAST);
  wire tx_last_data   = (tx_idx_ff == (seven_bit_i ? IDX_LAST_7 : IDX_LAST_8));
  wire tx_load_idle   = (tx_state_ff == TX_IDLE) & tx_enable_i & ~tx_empty_flag_ff;
  wire tx_enter_stop  = tx_bit_end & (((tx_state_ff == TX_DATA) & tx_last_data & ~has_extra)
                                      | (tx_state_ff == TX_EXTRA));
  wire tx_load_chain  = tx_enter_stop & ~tx_empty_flag_ff;
  wire tx_load        = tx_load_idle | tx_load_chain;
  wire [7:0] tx_char  = seven_bit_i ? {1'b0, tx_data_reg_ff[6:0]} : tx_data_reg_ff;
  // mp format sends the id bit in place of parity
  wire tx_extra_nxt   = multiproc_i ? id_bit_to_send_i : (^tx_char ^ parity_odd_i);

  // data register written by the host
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      tx_data_reg_ff <= DATA_RST;
    end else if (tx_write_i) begin
      tx_data_reg_ff <= tx_data_i;
    end
  end

  // shift register load, id bit latched at load time
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      tx_shift_reg_ff <= DATA_RST;
      tx_extra_ff     <= 1'b0;
    end else if (tx_load) begin
      tx_shift_reg_ff <= tx_char;
      tx_extra_ff     <= tx_extra_nxt;
    end else if (tx_bit_end && tx_state_ff == TX_DATA) begin
      tx_shift_reg_ff <= {1'b0, tx_shift_reg_ff[7:1]};
    end
  end

  // transmit sequencer; disabling the transmitter returns it to mark
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i || !tx_enable_i) begin
      tx_state_ff <= TX_IDLE;
      tx_sub_ff   <= 4'h0;
      tx_idx_ff   <= 3'h0;
      tx_line_ff  <= LINE_MARK;
      tx_stop2_ff <= 1'b0;
      tx_chain_ff <= 1'b0;
    end else begin
      tx_sub_ff <= tick_ff ? tx_sub_ff + 4'h1 : tx_sub_ff;
      case (tx_state_ff)
        // mark level until data is waiting
        TX_IDLE: begin
          tx_sub_ff <= 4'h0;
          if (tx_load_idle) begin
            tx_state_ff <= TX_START;
            tx_line_ff  <= LINE_SPACE;
          end
        end
        // one start bit
        TX_START: begin
          if (tx_bit_end) begin
            tx_state_ff <= TX_DATA;
            tx_idx_ff   <= 3'h0;
            tx_line_ff  <= tx_shift_reg_ff[0];
          end
        end
        // data bits, least significant first
        TX_DATA: begin
          if (tx_bit_end) begin
            tx_idx_ff  <= tx_idx_ff + 3'h1;
            tx_line_ff <= tx_shift_reg_ff[1];
            if (tx_last_data) begin
              tx_state_ff <= has_extra ? TX_EXTRA : TX_STOP;
              tx_line_ff  <= has_extra ? tx_extra_ff : LINE_MARK;
              tx_chain_ff <= tx_load_chain;
              tx_stop2_ff <= 1'b0;
            end
          end
        end
        // parity or id bit
        TX_EXTRA: begin
          if (tx_bit_end) begin
            tx_state_ff <= TX_STOP;
            tx_line_ff  <= LINE_MARK;
            tx_chain_ff <= tx_load_chain;
            tx_stop2_ff <= 1'b0;
          end
        end
        // one or two stop bits, then next frame or mark
        TX_STOP: begin
          if (tx_bit_end) begin
            if (two_stop_i && !tx_stop2_ff) begin
              tx_stop2_ff <= 1'b1;
            end else if (tx_chain_ff) begin
              tx_state_ff <= TX_START;
              tx_line_ff  <= LINE_SPACE;
            end else begin
              tx_state_ff <= TX_IDLE;
            end
          end
        end
        default: tx_state_ff <= TX_IDLE;
      endcase
    end
  end

  // empty set by every load, end set when no data is waiting at the stop bit
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      tx_empty_flag_ff <= TX_EMPTY_RST;
      tx_end_flag_ff   <= TX_END_RST;
    end else begin
      tx_empty_flag_ff <= ~tx_enable_i | tx_load | (tx_empty_flag_ff & ~tx_empty_clr_i);
      tx_end_flag_ff   <= ~tx_enable_i | (tx_enter_stop & tx_empty_flag_ff)
                          | (tx_end_flag_ff & ~tx_load);
    end
  end

  // ==========================================================
  // interrupt requests and output registers
  logic rx_full_irq_ff;
  logic rx_error_irq_ff;
  logic tx_empty_irq_ff;
  logic tx_end_irq_ff;

  // requests follow their flag and enable one cycle later
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      rx_full_irq_ff  <= 1'b0;
      rx_error_irq_ff <= 1'b0;
      tx_empty_irq_ff <= 1'b0;
      tx_end_irq_ff   <= 1'b0;
    end else begin
      rx_full_irq_ff  <= rx_full_flag_ff & rx_irq_enable_i;
      rx_error_irq_ff <= rx_err_any & rx_irq_enable_i;
      tx_empty_irq_ff <= tx_empty_flag_ff & tx_empty_irq_enable_i;
      tx_end_irq_ff   <= tx_end_flag_ff & tx_end_irq_enable_i;
    end
  end

  assign tx_line_o          = tx_line_ff;
  assign rx_data_o          = rx_data_reg_ff;
  assign rx_full_flag_o     = rx_full_flag_ff;
  assign overrun_flag_o     = overrun_flag_ff;
  assign framing_err_flag_o = framing_err_flag_ff;
  assign parity_err_flag_o  = parity_err_flag_ff;
  assign id_flag_bit_o      = id_flag_bit_ff;
  assign id_wait_enable_o   = id_wait_enable_ff;
  assign tx_empty_flag_o    = tx_empty_flag_ff;
  assign tx_end_flag_o      = tx_end_flag_ff;
  assign rx_full_irq_o      = rx_full_irq_ff;
  assign rx_error_irq_o     = rx_error_irq_ff;
  assign tx_empty_irq_o     = tx_empty_irq_ff;
  assign tx_end_irq_o       = tx_end_irq_ff;

  // ==========================================================
  // assertions
  AST_RX_HOLD_ON_ERR: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    (rx_state_ff == RX_IDLE) && rx_err_any |=> (rx_state_ff == RX_IDLE))
    else $error("receiver left idle with an error pending");
  AST_RX_OVERRUN_KEEP: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    do_overrun |=> $stable(rx_data_reg_ff) && overrun_flag_ff)
    else $error("overrun changed the data register");
  AST_RX_FRAMING: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    do_load && stop_bad |=> framing_err_flag_ff && !$rose(rx_full_flag_ff)
      && (rx_data_reg_ff == $past(rx_char)))
    else $error("framing error not flagged or data not loaded");
  AST_RX_PARITY: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    do_load && parity_bad |=> parity_err_flag_ff && !$rose(rx_full_flag_ff))
    else $error("parity error not flagged");
  AST_RX_SKIP: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    frame_done && frame_skip |=> !$rose(rx_full_flag_ff) && $stable(rx_data_reg_ff))
    else $error("data frame accepted during id wait");
  AST_RX_ID_CLEARS_WAIT: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    id_frame && !id_wait_set_i |=> !id_wait_enable_ff)
    else $error("id frame did not drop id wait");
  AST_RX_FULL_IRQ: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    $rose(rx_full_flag_ff) && rx_irq_enable_i |=> rx_full_irq_o)
    else $error("receive request missing");
  AST_RX_ERR_IRQ: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    rx_err_any && rx_irq_enable_i |=> rx_error_irq_o)
    else $error("error request missing");
  AST_TX_LOAD: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    tx_load_idle |=> tx_empty_flag_ff && (tx_state_ff == TX_START) && !tx_line_o)
    else $error("transmit load did not start a frame");
  AST_TX_END: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    tx_enter_stop && tx_empty_flag_ff |=> tx_end_flag_ff && tx_line_o)
    else $error("transmit end not set at stop bit");
  AST_TX_STOP_MARK: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    (tx_state_ff == TX_STOP) || (tx_state_ff == TX_IDLE) |-> tx_line_o)
    else $error("line not at mark during stop or idle");
endmodule // serial_unit
`default_nettype wire

// File: hdl/serial_unit_pkg.sv
// constants, state codes and reset values for the asynchronous serial unit
package serial_unit_pkg;
  // ==========================================================
  // frame geometry
  localparam int          DATA_W        = 8;      // widest character
  localparam logic [2:0]  IDX_LAST_8    = 3'h7;   // last data bit, 8-bit characters
  localparam logic [2:0]  IDX_LAST_7    = 3'h6;   // last data bit, 7-bit characters
  // ==========================================================
  // oversampling: sixteen sample ticks per bit
  localparam int          OVERSAMPLE    = 16;
  localparam logic [3:0]  SUB_LAST      = 4'(OVERSAMPLE - 1); // last tick of a bit
  localparam logic [3:0]  SUB_MID       = 4'(OVERSAMPLE / 2 - 1); // centre of the start bit
  localparam logic [15:0] DIV_RESET     = 16'h0000; // divider count after reset
  // ==========================================================
  // reset values of the flags and data registers, and the line levels
  localparam logic        TX_EMPTY_RST  = 1'b1;
  localparam logic        TX_END_RST    = 1'b1;
  localparam logic        LINE_MARK     = 1'b1;   // idle level of the line
  localparam logic        LINE_SPACE    = 1'b0;   // start bit level
  localparam logic [7:0]  DATA_RST      = 8'h00;
  // ==========================================================
  // receiver states, one-hot
  typedef enum logic [4:0] {
    RX_IDLE  = 5'b00001,
    RX_START = 5'b00010,
    RX_DATA  = 5'b00100,
    RX_EXTRA = 5'b01000,
    RX_STOP  = 5'b10000
  } rx_state_t;
  // transmitter states, one-hot
  typedef enum logic [4:0] {
    TX_IDLE  = 5'b00001,
    TX_START = 5'b00010,
    TX_DATA  = 5'b00100,
    TX_EXTRA = 5'b01000,
    TX_STOP  = 5'b10000
  } tx_state_t;
endpackage

// File: test/far_node.sv
// far-end serial node: drives the receive line and captures transmitted frames
`timescale 1ns/100ps
`default_nettype none
module far_node (
  input  wire logic core_clk_i,  // system clock
  input  wire logic tx_line_i,   // line from the unit
  output var logic  line_o       // line into the unit, pulled to mark
);
  logic lost;                    // capture gave up waiting
  // ==========================================
  // one bit lasts sixteen sample ticks
  task automatic hold(input logic b);
    line_o = b;
    repeat (16) @(negedge core_clk_i);
  endtask
  // start, data lsb first, optional extra bit, first stop, one idle bit
  task automatic send(input logic [7:0] d, input int n, input int xen,
                      input logic x, input logic stp);
    hold(1'b0);
    for (int i = 0; i < n; i++) hold(d[i]);
    if (xen != 0) hold(x);
    hold(stp);
    hold(1'b1);
  endtask
  // wait for a start bit, then sample eleven bit centres
  task automatic grab(output logic [10:0] f);
    int t;
    t = 0;
    while (tx_line_i !== 1'b0 && t < 3000) begin
      @(negedge core_clk_i);
      t++;
    end
    lost = (t >= 3000);
    repeat (8) @(negedge core_clk_i);
    for (int i = 0; i < 11; i++) begin
      f[i] = tx_line_i;
      if (i < 10) repeat (16) @(negedge core_clk_i);
    end
  endtask
  // idle mark at start
  initial begin
    line_o = 1'b1;
    lost = 1'b0;
  end
endmodule // far_node
`default_nettype wire

// File: test/serial_unit_tb.sv
// self-checking bench for the asynchronous serial unit
`timescale 1ns/100ps
`default_nettype none
module serial_unit_tb;
  import serial_unit_pkg::*;
  logic        core_clk_i, sys_rst_i, seven_bit_i, parity_en_i, parity_odd_i;
  logic        multiproc_i, two_stop_i, rx_enable_i, tx_enable_i, rx_irq_enable_i;
  logic        tx_empty_irq_enable_i, tx_end_irq_enable_i, rx_full_clr_i, err_clr_i;
  logic        id_wait_set_i, tx_write_i, id_bit_to_send_i, tx_empty_clr_i, rx_line_i;
  logic [15:0] baud_div_i;
  logic [7:0]  tx_data_i, rx_data_o;
  logic        tx_line_o, rx_full_flag_o, overrun_flag_o, framing_err_flag_o;
  logic        parity_err_flag_o, id_flag_bit_o, id_wait_enable_o, tx_empty_flag_o;
  logic        tx_end_flag_o, rx_full_irq_o, rx_error_irq_o, tx_empty_irq_o, tx_end_irq_o;
  logic [10:0] fr;
  int          num_errors, total_checks;
  serial_unit dut_u (.core_clk_i, .sys_rst_i, .baud_div_i, .seven_bit_i, .parity_en_i,
    .parity_odd_i, .multiproc_i, .two_stop_i, .rx_enable_i, .tx_enable_i, .rx_irq_enable_i,
    .tx_empty_irq_enable_i, .tx_end_irq_enable_i, .rx_line_i, .rx_full_clr_i, .err_clr_i,
    .id_wait_set_i, .tx_write_i, .tx_data_i, .id_bit_to_send_i, .tx_empty_clr_i, .tx_line_o,
    .rx_data_o, .rx_full_flag_o, .overrun_flag_o, .framing_err_flag_o, .parity_err_flag_o,
    .id_flag_bit_o, .id_wait_enable_o, .tx_empty_flag_o, .tx_end_flag_o, .rx_full_irq_o,
    .rx_error_irq_o, .tx_empty_irq_o, .tx_end_irq_o);
  far_node fn (.core_clk_i, .tx_line_i(tx_line_o), .line_o(rx_line_i));
  // ==========================================
  // compare and count
  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // one-cycle strobe: 0 rx clear, 1 error clear, 2 id wait, 3 tx empty clear, 4 tx write
  task automatic pulse(input int k);
    {tx_write_i, tx_empty_clr_i, id_wait_set_i, err_clr_i, rx_full_clr_i} = 5'(1 << k);
    @(negedge core_clk_i);
    {tx_write_i, tx_empty_clr_i, id_wait_set_i, err_clr_i, rx_full_clr_i} = 5'h00;
    @(negedge core_clk_i); // gap so back-to-back strobes never share a time step
  endtask
  // verdict and end of run
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // capture one transmitted frame, a lost start ends the run
  task automatic take(input logic [10:0] exp);
    fn.grab(fr);
    if (fn.lost) begin
      num_errors++;
      tally_and_finish();
    end else chk(12'(fr), 12'(exp));
  endtask
  // ==========================================
  // clock, 100 MHz
  initial begin
    core_clk_i = 1'b0;
    forever #5 core_clk_i = ~core_clk_i;
  end
  // main sequence, inputs change on falling edges
  initial begin
    {seven_bit_i, parity_en_i, parity_odd_i, multiproc_i, two_stop_i} = 5'h00;
    {rx_enable_i, tx_enable_i, rx_irq_enable_i} = 3'h7;
    {tx_empty_irq_enable_i, tx_end_irq_enable_i} = 2'h3;
    {tx_write_i, tx_empty_clr_i, id_wait_set_i, err_clr_i, rx_full_clr_i} = 5'h00;
    {tx_data_i, id_bit_to_send_i, baud_div_i, sys_rst_i} = {8'h00, 1'b0, 16'h0000, 1'b1};
    repeat (20) @(negedge core_clk_i);
    sys_rst_i = 1'b0;
    @(negedge core_clk_i);
    chk({tx_empty_flag_o, tx_end_flag_o, rx_full_flag_o}, 12'h006);
    fn.send(8'hA5, 8, 0, 1'b0, 1'b1);
    chk({rx_full_flag_o, rx_full_irq_o, rx_data_o}, 12'h3A5);
    fn.send(8'h3C, 8, 0, 1'b0, 1'b1);
    chk({overrun_flag_o, rx_error_irq_o, rx_data_o}, 12'h3A5);
    pulse(0);
    fn.send(8'h66, 8, 0, 1'b0, 1'b1);
    chk({rx_full_flag_o, rx_data_o}, 12'h0A5);
    pulse(1);
    parity_en_i = 1'b1;
    fn.send(8'h07, 8, 1, 1'b0, 1'b1);
    chk({parity_err_flag_o, rx_full_flag_o, rx_data_o}, 12'h207);
    pulse(1);
    parity_odd_i = 1'b1;
    fn.send(8'h07, 8, 1, 1'b0, 1'b1);
    chk({parity_err_flag_o, rx_full_flag_o, rx_data_o}, 12'h107);
    pulse(0);
    {parity_en_i, seven_bit_i, two_stop_i} = 3'b011;
    fn.send(8'h55, 7, 0, 1'b0, 1'b0);
    chk({framing_err_flag_o, rx_full_flag_o, rx_data_o}, 12'h255);
    pulse(1);
    {parity_en_i, seven_bit_i, two_stop_i, multiproc_i} = 4'b1001;
    pulse(2);
    fn.send(8'h11, 8, 1, 1'b0, 1'b1);
    chk({rx_full_flag_o, id_wait_enable_o}, 12'h001);
    fn.send(8'h43, 8, 1, 1'b1, 1'b1);
    chk({rx_full_flag_o, id_wait_enable_o, id_flag_bit_o, parity_err_flag_o, rx_data_o},
        12'hA43);
    pulse(0);
    fn.send(8'h5A, 8, 1, 1'b0, 1'b1);
    chk({rx_full_flag_o, id_flag_bit_o, rx_data_o}, 12'h25A);
    pulse(0);
    {tx_data_i, id_bit_to_send_i} = {8'h3C, 1'b1};
    pulse(4);
    pulse(3);
    @(negedge core_clk_i);
    {tx_data_i, id_bit_to_send_i} = {8'hC3, 1'b0};
    pulse(4);
    pulse(3);
    take({2'b11, 8'h3C, 1'b0});
    chk(tx_end_flag_o, 12'h000);
    take({2'b10, 8'hC3, 1'b0});
    chk({tx_empty_flag_o, tx_empty_irq_o, tx_end_flag_o, tx_end_irq_o}, 12'h00F);
    tally_and_finish();
  end
endmodule // serial_unit_tb
`default_nettype wire
